// File: rtl/wcr_map.vh
// register map, field positions, reset values and timing counts of the watchdog block
// assumes: included by the watchdog design files only
`ifndef WCR_MAP_VH
`define WCR_MAP_VH
`define WCR_OFF_CONTROL    12'h000
`define WCR_OFF_SERVICE    12'h004
`define WCR_OFF_AUXCTL     12'h008
`define WCR_OFF_IRQ_STAT   12'h00C
`define WCR_OFF_IRQ_MASK   12'h010
`define WCR_CTL_CLE        7
`define WCR_CTL_CLL        6
`define WCR_CTL_FCL        5
`define WCR_CTL_FWD        4
`define WCR_CTL_SUP        3
`define WCR_CTL_RATE_HI    2
`define WCR_CTL_RATE_LO    0
`define WCR_AUX_HALT       0
`define WCR_AUX_BYP        1
`define WCR_IRQ_WDT        0
`define WCR_IRQ_CLK        1
`define WCR_IRQ_KEY        2
`define WCR_RST_CONTROL    8'h00
`define WCR_RST_AUXCTL     2'h0
`define WCR_RST_IRQ_MASK   3'h0
`define WCR_KEY_FIRST      8'h55
`define WCR_KEY_SECOND     8'hAA
`define WCR_SERVICE_READ   8'h00
`define WCR_PRE_EXP        13
`define WCR_BYP_EXP        2
`define WCR_CLK_PERIOD_PS  4000
`define WCR_LOSS_TIME_NS   2
`define WCR_LOSS_TIME_UNIT 1000
`define WCR_LOSS_CYC       ((`WCR_LOSS_TIME_NS * `WCR_LOSS_TIME_UNIT * 1000 + `WCR_CLK_PERIOD_PS - 1) / `WCR_CLK_PERIOD_PS)
`endif

// File: rtl/wcr_clkmon.v
// clock-loss monitor: counts bus cycles between edges of the watched clock
// assumes: watched clock arrives asynchronous; bus clock runs independently of it
`timescale 1ns/1ps
`include "wcr_map.vh"
module wcr_clkmon #(
   parameter LOSS_CYC = `WCR_LOSS_CYC,
   parameter CW       = 12
) (
   input  wire pclk,
   input  wire presetn,
   input  wire mon_clk,
   output reg  loss_q
);
   reg          s1_q;
   reg          s2_q;
   reg          s3_q;
   reg [CW-1:0] cnt_q;
   wire         edge_seen = s2_q ^ s3_q;

   // no edge within the delay flags loss; runs on bus clock only  [RULE16]
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q   <= 1'b0;
         s2_q   <= 1'b0;
         s3_q   <= 1'b0;
         cnt_q  <= {CW{1'b0}};
         loss_q <= 1'b0;
      end else begin
         s1_q <= mon_clk;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (edge_seen) begin
            cnt_q  <= {CW{1'b0}};
            loss_q <= 1'b0;
         end else if (cnt_q == LOSS_CYC[CW-1:0] - 1'b1) begin
            loss_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule // wcr_clkmon

// File: rtl/wcr_top.v
// watchdog timer with clock-loss reset, APB register slave
// assumes: special_mode, wait_mode and mon_clk are asynchronous pins
// Operation
// RULE1: clock-loss enable 0 means monitor off; 1 means lost clock starts a reset
// RULE2: while the lock bit is set, the enable bit is ignored
// RULE3: lock bit write-once in normal mode, free in special; set keeps monitor on
// RULE4: lock 0 follows enable; lock 1 always resets on lost clock
// RULE5: software clears enable before stop and keeps lock at zero then
// RULE6: force clock-loss reset works if monitor on; special mode writes only
// RULE7: force watchdog reset works if watchdog on; special mode writes only
// RULE8: suppress blocks every reset and both force bits; special mode writes only
// RULE9: watchdog ticks from bus clock divided by two to the thirteenth
// RULE10: special-mode bypass keeps only two stages of the fixed prescaler
// RULE11: rate code 0 off, codes 1..7 divide by 2^13,15,17,19,21,22,23
// RULE12: rate field write-once in normal mode, any time in special mode
// RULE13: software writes first key then second key before each timeout
// RULE14: any other service value resets at once; service reads zero; the code resets on it only while the rate code is nonzero
// RULE15: reaching the timeout without a finished key pair resets the system
// RULE16: lost clock means no edges within a delay, timed by the bus clock
// RULE17: halt bit stops the watchdog in wait mode; clear keeps it running
// RULE18: second key after first key restarts the count; alone it does not
// RULE19: write-once fields take only the first write after reset in normal mode
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "wcr_map.vh"
module wcr_top #(
   parameter PRE_EXP  = `WCR_PRE_EXP,
   parameter LOSS_CYC = `WCR_LOSS_CYC
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        special_mode,
   input  wire        wait_mode,
   input  wire        mon_clk,
   output reg         wdt_reset,
   output reg         clk_loss_reset,
   output reg         irq
);
   localparam KEY_IDLE  = 1'b0;
   localparam KEY_ARMED = 1'b1;
   localparam CNT_W     = 24;
   localparam [7:0] RST_CTL = `WCR_RST_CONTROL;
   localparam [4:0] PRE_E5  = PRE_EXP;
   localparam [4:0] BYP_E5  = `WCR_BYP_EXP;

   reg             spec_s1_q;
   reg             spec_q;
   reg             wait_s1_q;
   reg             wait_q;
   reg             cle_q;
   reg             cll_q;
   reg             sup_q;
   reg  [2:0]      rate_q;
   reg             cll_wr_q;
   reg             rate_wr_q;
   reg             halt_q;
   reg             byp_q;
   reg  [2:0]      irq_stat_q;
   reg  [2:0]      irq_mask_q;
   reg             key_st_q;
   reg  [CNT_W-1:0] cnt_q;
   wire            loss;

   // extra exponent added by each rate code  [RULE11]
   function [4:0] rate_exp;
      input [2:0] code;
      begin
         case (code)
            3'h1:    rate_exp = 5'd0;
            3'h2:    rate_exp = 5'd2;
            3'h3:    rate_exp = 5'd4;
            3'h4:    rate_exp = 5'd6;
            3'h5:    rate_exp = 5'd8;
            3'h6:    rate_exp = 5'd9;
            3'h7:    rate_exp = 5'd10;
            default: rate_exp = 5'd0;
         endcase
      end
   endfunction

   // register index decode, shared by read and write paths
   function [2:0] reg_sel;
      input [11:0] a;
      begin
         case (a)
            `WCR_OFF_CONTROL:  reg_sel = 3'h1;
            `WCR_OFF_SERVICE:  reg_sel = 3'h2;
            `WCR_OFF_AUXCTL:   reg_sel = 3'h3;
            `WCR_OFF_IRQ_STAT: reg_sel = 3'h4;
            `WCR_OFF_IRQ_MASK: reg_sel = 3'h5;
            default:           reg_sel = 3'h0;
         endcase
      end
   endfunction

   // pin synchronisers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spec_s1_q <= 1'b0;
         spec_q    <= 1'b0;
         wait_s1_q <= 1'b0;
         wait_q    <= 1'b0;
      end else begin
         spec_s1_q <= special_mode;
         spec_q    <= spec_s1_q;
         wait_s1_q <= wait_mode;
         wait_q    <= wait_s1_q;
      end
   end

   wcr_clkmon #(
      .LOSS_CYC (LOSS_CYC),
      .CW       (16)
   ) u_clkmon (
      .pclk    (pclk),
      .presetn (presetn),
      .mon_clk (mon_clk),
      .loss_q  (loss)
   );

   // bus access decode
   wire        acc_first = psel & penable & ~pready;
   wire        acc_done  = psel & penable & pready;
   wire [2:0]  sel       = reg_sel(paddr);
   wire        wr        = acc_done & pwrite;
   wire        wr_ctl    = wr & (sel == 3'h1);
   wire        wr_svc    = wr & (sel == 3'h2);
   wire        wr_aux    = wr & (sel == 3'h3);
   wire        wr_mask   = wr & (sel == 3'h5);
   wire        rd_stat   = acc_first & ~pwrite & (sel == 3'h4);
   wire [7:0]  wd        = pwdata[7:0];

   // monitor and watchdog enables
   wire mon_on = cll_q | cle_q;                                     // [RULE2] [RULE4] [RULE1]
   wire wdt_on = (rate_q != 3'h0);                                  // [RULE11]

   // force bits act only on a special-mode write  [RULE6] [RULE7]
   wire force_clk = wr_ctl & spec_q & wd[`WCR_CTL_FCL];
   wire force_wdt = wr_ctl & spec_q & wd[`WCR_CTL_FWD];

   // timeout count: prescaler plus rate division, bypass in special mode
   wire [4:0]       pre_e   = (byp_q & spec_q) ? BYP_E5 : PRE_E5;   // [RULE10] [RULE9]
   wire [4:0]       tot_e   = pre_e + rate_exp(rate_q);
   wire [CNT_W-1:0] limit   = ({{(CNT_W-1){1'b0}}, 1'b1} << tot_e) - 1'b1;
   wire             tmo     = wdt_on & (cnt_q == limit);            // [RULE15]
   wire             key_ok  = (wd == `WCR_KEY_FIRST) | (wd == `WCR_KEY_SECOND);
   wire             bad_key = wr_svc & wdt_on & ~key_ok;            // [RULE14]
   wire             restart = wr_svc & (wd == `WCR_KEY_SECOND) & (key_st_q == KEY_ARMED);
   wire             halted  = halt_q & wait_q;                      // [RULE17]

   // reset sources, all gated by suppress  [RULE8]
   wire wdt_ev = tmo | bad_key | (force_wdt & wdt_on);
   wire clk_ev = mon_on & (loss | force_clk);

   // control register with write-once fields
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cle_q     <= RST_CTL[`WCR_CTL_CLE];
         cll_q     <= 1'b0;
         sup_q     <= 1'b0;
         rate_q    <= 3'h0;
         cll_wr_q  <= 1'b0;
         rate_wr_q <= 1'b0;
      end else if (wr_ctl) begin
         cle_q <= wd[`WCR_CTL_CLE];
         if (spec_q | ~cll_wr_q) begin                               // [RULE3] [RULE19]
            cll_q    <= wd[`WCR_CTL_CLL];
            cll_wr_q <= 1'b1;
         end
         if (spec_q | ~rate_wr_q) begin                              // [RULE12] [RULE19]
            rate_q    <= wd[`WCR_CTL_RATE_HI:`WCR_CTL_RATE_LO];
            rate_wr_q <= 1'b1;
         end
         if (spec_q) begin                                           // [RULE8]
            sup_q <= wd[`WCR_CTL_SUP];
         end
      end
   end

   // auxiliary control: halt in wait, bypass for test
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_q <= 1'b0;
         byp_q  <= 1'b0;
      end else if (wr_aux) begin
         halt_q <= wd[`WCR_AUX_HALT];                                 // [RULE17]
         if (spec_q) begin                                           // [RULE10]
            byp_q <= wd[`WCR_AUX_BYP];
         end
      end
   end

   // key sequence tracker  [RULE18]
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_st_q <= KEY_IDLE;
      end else if (wr_svc) begin
         case (key_st_q)
            KEY_IDLE:  key_st_q <= (wd == `WCR_KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
            KEY_ARMED: key_st_q <= (wd == `WCR_KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
            default:   key_st_q <= KEY_IDLE;
         endcase
      end
   end

   // timeout counter, restarted by a completed key pair  [RULE18] [RULE9]
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= {CNT_W{1'b0}};
      end else if (restart | ~wdt_on | tmo) begin
         cnt_q <= {CNT_W{1'b0}};
      end else if (!halted) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // reset outputs, one-cycle pulses  [RULE15] [RULE14] [RULE1] [RULE8]
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_reset      <= 1'b0;
         clk_loss_reset <= 1'b0;
      end else begin
         wdt_reset      <= wdt_ev & ~sup_q;
         clk_loss_reset <= clk_ev & ~sup_q & ~clk_loss_reset;
      end
   end

   // interrupt status: sticky, read clears, a new event wins over the clear
   wire [2:0] ev_vec;
   assign ev_vec[`WCR_IRQ_WDT] = tmo;
   assign ev_vec[`WCR_IRQ_CLK] = clk_ev & ~clk_loss_reset;
   assign ev_vec[`WCR_IRQ_KEY] = bad_key;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= 3'h0;
         irq_mask_q <= `WCR_RST_IRQ_MASK;
         irq        <= 1'b0;
      end else begin
         irq_stat_q <= (rd_stat ? 3'h0 : irq_stat_q) | ev_vec;
         if (wr_mask) begin
            irq_mask_q <= wd[2:0];
         end
         irq <= |(((rd_stat ? 3'h0 : irq_stat_q) | ev_vec) & (wr_mask ? wd[2:0] : irq_mask_q));
      end
   end

   // read mux
   reg [31:0] rd_d;
   always @* begin
      rd_d = 32'h0000_0000;
      case (sel)
         3'h1:    rd_d = {24'h00_0000, cle_q, cll_q, 1'b0, 1'b0, sup_q, rate_q};
         3'h2:    rd_d = {24'h00_0000, `WCR_SERVICE_READ};          // [RULE14]
         3'h3:    rd_d = {30'h0000_0000, byp_q, halt_q};
         3'h4:    rd_d = {29'h0000_0000, irq_stat_q};
         3'h5:    rd_d = {29'h0000_0000, irq_mask_q};
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // APB slave: one wait state, data and error registered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= acc_first;
         pslverr <= acc_first & (sel == 3'h0);
         if (acc_first & ~pwrite) begin
            prdata <= rd_d;
         end
      end
   end
endmodule // wcr_top

// File: dv/wcr_checker.sv
// bus timing and reset-output checks at the watchdog block ports
// assumes: bound onto wcr_top, one clock domain
`timescale 1ns/1ps
module wcr_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        wdt_reset,
   input wire logic        clk_loss_reset,
   input wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_one_wait: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
      else $error("ready not in second access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_unmapped_err: assert property (pready && paddr > 12'h010 |-> pslverr)
      else $error("unmapped access not refused");
   chk_service_zero: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata == 32'h0)
      else $error("service register read not zero");
   chk_rdata_hold: assert property (!(psel && !pwrite) |=> $stable(prdata))
      else $error("read data moved without a read");
   chk_reset_quiet: assert property ($rose(presetn) |-> !wdt_reset && !clk_loss_reset && !irq)
      else $error("output active right after reset");
   chk_loss_toggle: assert property (clk_loss_reset |=> !clk_loss_reset)
      else $error("clock loss pulse too long");
endmodule // wcr_checker

// File: dv/testbench.sv
// directed register-level tests of the watchdog and clock-loss block
// assumes: design instantiated with short prescaler and loss delay
`timescale 1ns/1ps
module testbench;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, er, wdt_reset, clk_loss_reset, irq;
   logic        special_mode = 0, wait_mode = 0, mon_clk = 0, mon_run = 1;
   int          mismatches = 0, samples_checked = 0, wdt_cnt = 0, cl_cnt = 0, n;
   logic [1:0]  mdiv = 0;
   wcr_top #(.PRE_EXP(2), .LOSS_CYC(20)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .special_mode(special_mode), .wait_mode(wait_mode), .mon_clk(mon_clk),
      .wdt_reset(wdt_reset), .clk_loss_reset(clk_loss_reset), .irq(irq));
   always #2 pclk = ~pclk;
   // watched clock, stands still when stopped
   always @(posedge pclk) begin
      if (mon_run) begin
         mdiv <= mdiv + 2'h1;
         if (mdiv == 2'h1) mon_clk <= ~mon_clk;
      end
      if (wdt_reset === 1'b1) wdt_cnt++;
      if (clk_loss_reset === 1'b1) cl_cnt++;
   end
   task automatic stop_test();
      if (mismatches == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic w(input int c);
      repeat (c) @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(rd, e);
   endtask
   task automatic svc();
      wr(12'h004, 32'h55);
      wr(12'h004, 32'hAA);
   endtask
   initial begin
      w(12);
      presetn <= 1;
      w(1);
      rc(12'h000, 32'h00);
      rc(12'h004, 32'h00);
      rc(12'h020, 32'h00);
      cmp(er, 1);
      wr(12'h000, 32'h04);
      wr(12'h000, 32'h17);
      rc(12'h000, 32'h04);
      repeat (6) begin svc(); w(100); end
      cmp(wdt_cnt, 0);
      svc();
      repeat (4) begin w(80); wr(12'h004, 32'hAA); end
      cmp(wdt_cnt > 0, 1);
      rc(12'h00C, 32'h01);
      wr(12'h010, 32'h04);
      svc();
      n = wdt_cnt;
      wr(12'h004, 32'h12);
      w(2);
      cmp(wdt_cnt > n, 1);
      cmp(irq, 1);
      apb(1'b0, 12'h00C, 32'h0);
      cmp(rd & 32'h4, 32'h4);
      w(1);
      cmp(irq, 0);
      special_mode <= 1;
      w(5);
      n = wdt_cnt;
      wr(12'h000, 32'h14);
      w(3);
      cmp(wdt_cnt > n, 1);
      wr(12'h000, 32'h0C);
      w(2);
      n = wdt_cnt;
      wr(12'h000, 32'h1C);
      wr(12'h004, 32'h12);
      w(300);
      cmp(wdt_cnt, n);
      rc(12'h000, 32'h0C);
      wr(12'h000, 32'h04);
      mon_run <= 0;
      w(60);
      cmp(cl_cnt, 0);
      wr(12'h000, 32'h84);
      w(60);
      cmp(cl_cnt > 0, 1);
      mon_run <= 1;
      w(40);
      n = cl_cnt;
      wr(12'h000, 32'hE4);
      w(4);
      cmp(cl_cnt > n, 1);
      w(40);
      n = cl_cnt;
      wr(12'h000, 32'h44);
      mon_run <= 0;
      w(60);
      cmp(cl_cnt > n, 1);
      mon_run <= 1;
      wr(12'h008, 32'h03);
      rc(12'h008, 32'h03);
      wait_mode <= 1;
      w(4);
      svc();
      n = wdt_cnt;
      w(400);
      cmp(wdt_cnt, n);
      wait_mode <= 0;
      w(300);
      cmp(wdt_cnt > n, 1);
      stop_test();
   end
   initial begin
      w(40000);
      mismatches++;
      stop_test();
   end
endmodule // testbench
bind wcr_top wcr_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .wdt_reset(wdt_reset), .clk_loss_reset(clk_loss_reset), .irq(irq));
